// >>> rtl/psc_ctrl.sv
// Top: configuration, compare registers, write locks, interrupts and ADC sync of the controller
//
// Functional notes
// - End-of-cycle interrupt flag sets on RB match when enabled.
// - End-of-enhanced-cycle flag sets on RB match in the last enhanced cycle, count 15.
// - Capture flag sets on retrigger, counter capture or synchronisation error.
// - Output D carries generator B when select bit 7 clear, A when set.
// - Output C carries generator A when select bit 6 clear, B when set.
// - Ramp modes: sync code picks SA, RA/fault A, SB, RB/fault B.
// - Centered: code 00 RA match counting down, 01 counting up, else none.
// - Bit 3 enables the D pin, driven from generator B path.
// - Bit 2 enables the B pin following generator B.
// - Bit 1 enables the C pin, driven from generator A path.
// - Bit 0 enables the A pin following generator A.
// - Four write-only compare registers, reset zero, 12 bits compared with counter.
// - RB bits 15:12 carry the flank width modulation value.
// - Compare writes go through one shared temporary high byte.
// - Half duty mode: each RB update copies RB to RA, SB to SA.
// - Autolock holds writes; committed at cycle end if RB written last.
// - Autolock prevails over the manual lock when both are set.
// - Manual lock buffers writes until the lock bit returns to zero.
// - Mode field: 00 one, 01 two, 10 four ramp, 11 centered.
// - Polarity bit: 0 active low, 1 active high; ignored under matrix.
// - Matrix enable makes A and B outputs follow per-ramp matrix bits.
`timescale 1ns/100ps
`default_nettype none
module psc_ctrl
  import psc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [CMP_W-1:0] count_in,
  input wire logic count_down_in,
  input wire logic cycle_end_in,
  input wire logic [3:0] enh_cycle_in,
  input wire logic [1:0] ramp_in,
  input wire logic wave_a_in,
  input wire logic wave_b_in,
  input wire logic fault_a_in,
  input wire logic fault_b_in,
  input wire logic retrigger_in,
  input wire logic capture_in,
  input wire logic sync_error_in,
  output logic [3:0] wave_pin_out,
  output logic [3:0] wave_pin_oe_out,
  output logic adc_sync_out,
  output logic irq_out,
  output logic fast_clock_select_out,
  output logic [1:0] ramp_mode_select_out,
  output logic [3:0] flank_width_out
);
  // ==========================================================
  // Shadow (software-visible) and active registers
  logic [7:0] temp_hi;
  logic [7:0] cfg;
  logic [7:0] soc_sh;
  logic [7:0] mat_sh;
  logic [15:0] sa_sh;
  logic [15:0] ra_sh;
  logic [15:0] sb_sh;
  logic [15:0] rb_sh;
  logic [2:0] irq_en;
  logic [2:0] irq_st;
  logic rb_last;
  psc_cmp_if act ();
  logic sa_hit;
  logic ra_hit;
  logic sb_hit;
  logic rb_hit;
  logic [3:0] pin_d;
  logic [3:0] oe_d;
  logic wr_lo;
  logic commit;
  logic [2:0] ev;
  logic next_sync;

  function automatic logic is_wr(input logic [3:0] a, input logic [3:0] r, input logic w);
    is_wr = w && (a == r);
  endfunction

  assign wr_lo = wr_in && (addr_in == REG_SET_A_LO || addr_in == REG_RESET_A_LO
                 || addr_in == REG_SET_B_LO || addr_in == REG_RESET_B_LO);

  // ==========================================================
  // Temporary high byte, shared by every sixteen-bit register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      temp_hi <= RESET_BYTE;
    end else if (wr_in && (addr_in == REG_SET_A_HI || addr_in == REG_RESET_A_HI
                 || addr_in == REG_SET_B_HI || addr_in == REG_RESET_B_HI)) begin
      temp_hi <= wdata_in;
    end
  end

  // Low-byte write commits the pair in one cycle; high byte alone stores nothing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sa_sh <= RESET_WORD;
      ra_sh <= RESET_WORD;
      sb_sh <= RESET_WORD;
      rb_sh <= RESET_WORD;
    end else begin
      if (is_wr(addr_in, REG_SET_A_LO, wr_in)) begin
        sa_sh <= {4'h0, temp_hi[3:0], wdata_in};
      end
      if (is_wr(addr_in, REG_RESET_A_LO, wr_in)) begin
        ra_sh <= {4'h0, temp_hi[3:0], wdata_in};
      end
      if (is_wr(addr_in, REG_SET_B_LO, wr_in)) begin
        sb_sh <= {4'h0, temp_hi[3:0], wdata_in};
      end
      if (is_wr(addr_in, REG_RESET_B_LO, wr_in)) begin
        rb_sh <= {temp_hi, wdata_in};
      end
    end
  end

  // Configuration, output configuration, matrix and interrupt enables
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg <= RESET_BYTE;
      soc_sh <= RESET_BYTE;
      mat_sh <= RESET_BYTE;
      irq_en <= 3'h0;
    end else if (wr_in) begin
      case (addr_in)
        REG_CTRL_CFG: cfg <= wdata_in;
        REG_SYNC_OUT_CFG: soc_sh <= wdata_in;
        REG_MATRIX: mat_sh <= wdata_in;
        REG_IRQ_ENABLE: irq_en <= wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Lock handling: autolock waits for RB-last and cycle end; manual waits for release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rb_last <= 1'b0;
    end else begin
      if (commit) begin
        rb_last <= 1'b0;
      end else if (wr_lo) begin
        rb_last <= is_wr(addr_in, REG_RESET_B_LO, wr_in);
      end
    end
  end

  always_comb begin
    if (cfg[CFG_ALOCK]) begin
      commit = cycle_end_in && rb_last;
    end else if (cfg[CFG_MLOCK]) begin
      commit = 1'b0;
    end else begin
      commit = 1'b1; // Unlocked: shadow passes straight through, one cycle later
    end
  end

  // Active copies; half duty mode mirrors the B pair into the A pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      act.set_a <= RESET_WORD;
      act.reset_a <= RESET_WORD;
      act.set_b <= RESET_WORD;
      act.reset_b <= RESET_WORD;
      act.soc <= RESET_BYTE;
      act.matrix <= RESET_BYTE;
    end else if (commit) begin
      act.set_b <= sb_sh;
      act.reset_b <= rb_sh;
      act.soc <= soc_sh;
      act.matrix <= mat_sh;
      act.set_a <= cfg[CFG_HALF] ? sb_sh : sa_sh;
      act.reset_a <= cfg[CFG_HALF] ? rb_sh : ra_sh;
    end
  end
  assign act.cfg = cfg;

  // ==========================================================
  psc_match u_match (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .count_in(count_in),
    .cmp(act.dst),
    .sa_hit_out(sa_hit),
    .ra_hit_out(ra_hit),
    .sb_hit_out(sb_hit),
    .rb_hit_out(rb_hit)
  );

  psc_outsel u_outsel (
    .wave_a_in(wave_a_in),
    .wave_b_in(wave_b_in),
    .ramp_in(ramp_in),
    .cmp(act.dst),
    .pin_out(pin_d),
    .pin_oe_out(oe_d)
  );

  // ==========================================================
  // Interrupt flags: set wins over a write-one-to-clear in the same cycle
  always_comb begin
    ev[IRQ_EC] = irq_en[IRQ_EC] && rb_hit;
    ev[IRQ_EEC] = irq_en[IRQ_EEC] && rb_hit && (enh_cycle_in == LAST_ENH_CYCLE);
    ev[IRQ_CAPTURE_EVENT_IRQ] = irq_en[IRQ_CAPTURE_EVENT_IRQ] && (retrigger_in || capture_in || sync_error_in);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_st <= 3'h0;
    end else begin
      irq_st <= (irq_st & ~(is_wr(addr_in, REG_IRQ_STATUS, wr_in) ? wdata_in[2:0] : 3'h0)) | ev;
    end
  end

  // ADC sync source per running mode
  always_comb begin
    next_sync = 1'b0;
    if (psc_mode_e'(cfg[CFG_MODE_HI:CFG_MODE_LO]) == PSC_CENTERED) begin
      case (psc_sync_e'(act.soc[SOC_SYNC_HI:SOC_SYNC_LO]))
        PSC_SYNC_SA: next_sync = ra_hit && count_down_in;
        PSC_SYNC_RA: next_sync = ra_hit && !count_down_in;
        default: next_sync = 1'b0;
      endcase
    end else begin
      case (psc_sync_e'(act.soc[SOC_SYNC_HI:SOC_SYNC_LO]))
        PSC_SYNC_SA: next_sync = sa_hit;
        PSC_SYNC_RA: next_sync = ra_hit || fault_a_in;
        PSC_SYNC_SB: next_sync = sb_hit;
        PSC_SYNC_RB: next_sync = rb_hit || fault_b_in;
        default: next_sync = 1'b0;
      endcase
    end
  end

  // Registered outputs; sync pulse lasts one clock even if the match holds
  logic sync_prev;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_sync_out <= 1'b0;
      sync_prev <= 1'b0;
      wave_pin_out <= 4'h0;
      wave_pin_oe_out <= 4'h0;
      irq_out <= 1'b0;
      fast_clock_select_out <= 1'b0;
      ramp_mode_select_out <= 2'h0;
      flank_width_out <= 4'h0;
    end else begin
      sync_prev <= next_sync;
      adc_sync_out <= next_sync && !sync_prev;
      wave_pin_out <= pin_d;
      wave_pin_oe_out <= oe_d;
      irq_out <= |irq_st;
      fast_clock_select_out <= cfg[CFG_FAST];
      ramp_mode_select_out <= cfg[CFG_MODE_HI:CFG_MODE_LO];
      flank_width_out <= act.reset_b[15:12];
    end
  end

  // Read port: compare registers are write-only and read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= RESET_BYTE;
    end else if (rd_in) begin
      case (addr_in)
        REG_CTRL_CFG: rdata_out <= cfg;
        REG_SYNC_OUT_CFG: rdata_out <= soc_sh;
        REG_MATRIX: rdata_out <= mat_sh;
        REG_IRQ_ENABLE: rdata_out <= {5'h00, irq_en};
        REG_IRQ_STATUS: rdata_out <= {5'h00, irq_st};
        default: rdata_out <= RESET_BYTE;
      endcase
    end else begin
      rdata_out <= RESET_BYTE;
    end
  end

  // ==========================================================
  // Checks
  property p_ec_set;
    @(posedge clk_in) disable iff (rst_in) (irq_en[0] && rb_hit) |=> irq_st[0];
  endproperty
  a_ec_set: assert property (p_ec_set) else $error("EC flag not set");
  property p_eec_set;
    @(posedge clk_in) disable iff (rst_in)
      (irq_en[1] && rb_hit && enh_cycle_in == 4'hF) |=> irq_st[1];
  endproperty
  a_eec_set: assert property (p_eec_set) else $error("EEC flag not set");
  property p_capture_event_irq_set;
    @(posedge clk_in) disable iff (rst_in)
      (irq_en[2] && (retrigger_in || capture_in || sync_error_in)) |=> irq_st[2];
  endproperty
  a_capture_event_irq_set: assert property (p_capture_event_irq_set) else $error("Capture flag not set");
  // Enables gate flag setting; a disabled source never raises its flag
  property p_ec_gate;
    @(posedge clk_in) disable iff (rst_in)
      (!irq_en[IRQ_EC] && !irq_st[IRQ_EC]) |=> !irq_st[IRQ_EC];
  endproperty
  a_ec_gate: assert property (p_ec_gate) else $error("EC flag set while disabled");
  property p_sync_mute;
    @(posedge clk_in) disable iff (rst_in)
      (cfg[CFG_MODE_HI:CFG_MODE_LO] == 2'b11 && act.soc[SOC_SYNC_HI]) |=> !adc_sync_out;
  endproperty
  a_sync_mute: assert property (p_sync_mute) else $error("Centered sync leaked");
  property p_sync_one;
    @(posedge clk_in) disable iff (rst_in) adc_sync_out |=> !adc_sync_out;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("Sync pulse too long");
  property p_mlock_hold;
    @(posedge clk_in) disable iff (rst_in)
      (cfg[5] && !cfg[6] && $past(cfg[5]) && !$past(cfg[6])) |-> $stable(act.set_b);
  endproperty
  a_mlock_hold: assert property (p_mlock_hold) else $error("Manual lock leaked");
  property p_alock_hold;
    @(posedge clk_in) disable iff (rst_in) (cfg[6] && !(cycle_end_in && rb_last))
      |=> $stable(act.soc);
  endproperty
  a_alock_hold: assert property (p_alock_hold) else $error("Autolock leaked");
  property p_half;
    @(posedge clk_in) disable iff (rst_in) (commit && cfg[7]) |=> act.reset_a == act.reset_b;
  endproperty
  a_half: assert property (p_half) else $error("Half duty copy missing");
  property p_pair;
    @(posedge clk_in) disable iff (rst_in) (wr_in && addr_in == REG_RESET_B_LO)
      |=> rb_sh == {$past(temp_hi), $past(wdata_in)};
  endproperty
  a_pair: assert property (p_pair) else $error("RB pair wrong");
  property p_oe;
    @(posedge clk_in) disable iff (rst_in) 1'b1 |=> wave_pin_oe_out[1] == $past(act.soc[2]);
  endproperty
  a_oe: assert property (p_oe) else $error("B pin enable wrong");
  c_sync: cover property (@(posedge clk_in) adc_sync_out);
  c_irq: cover property (@(posedge clk_in) irq_out);
  c_alock: cover property (@(posedge clk_in) cfg[6] && commit);
  c_half: cover property (@(posedge clk_in) commit && cfg[CFG_HALF]);
endmodule
`default_nettype wire

// >>> rtl/psc_pkg.sv
// Package: register map, field positions and enumerations of the power stage controller layer
package psc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] REG_SYNC_OUT_CFG = 4'h0;
  localparam logic [3:0] REG_CTRL_CFG = 4'h1;
  localparam logic [3:0] REG_MATRIX = 4'h2;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
  localparam logic [3:0] REG_SET_A_LO = 4'h5;
  localparam logic [3:0] REG_SET_A_HI = 4'h6;
  localparam logic [3:0] REG_RESET_A_LO = 4'h7;
  localparam logic [3:0] REG_RESET_A_HI = 4'h8;
  localparam logic [3:0] REG_SET_B_LO = 4'h9;
  localparam logic [3:0] REG_SET_B_HI = 4'hA;
  localparam logic [3:0] REG_RESET_B_LO = 4'hB;
  localparam logic [3:0] REG_RESET_B_HI = 4'hC;
  // Synchro and output configuration fields
  localparam int SOC_D_SEL = 7;
  localparam int SOC_C_SEL = 6;
  localparam int SOC_SYNC_HI = 5;
  localparam int SOC_SYNC_LO = 4;
  localparam int SOC_D_EN = 3;
  localparam int SOC_B_EN = 2;
  localparam int SOC_C_EN = 1;
  localparam int SOC_A_EN = 0;
  // Controller configuration fields
  localparam int CFG_HALF = 7;
  localparam int CFG_ALOCK = 6;
  localparam int CFG_MLOCK = 5;
  localparam int CFG_MODE_HI = 4;
  localparam int CFG_MODE_LO = 3;
  localparam int CFG_POL = 2;
  localparam int CFG_FAST = 1;
  localparam int CFG_MATRIX = 0;
  // Interrupt bits
  localparam int IRQ_EC = 0;
  localparam int IRQ_EEC = 1;
  localparam int IRQ_CAPTURE_EVENT_IRQ = 2;
  localparam int CMP_W = 12;
  localparam logic [3:0] LAST_ENH_CYCLE = 4'hF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum logic [1:0] {
    PSC_ONE_RAMP,
    PSC_TWO_RAMP,
    PSC_FOUR_RAMP,
    PSC_CENTERED
  } psc_mode_e;
  typedef enum logic [1:0] {
    PSC_SYNC_SA,
    PSC_SYNC_RA,
    PSC_SYNC_SB,
    PSC_SYNC_RB
  } psc_sync_e;
endpackage

// >>> rtl/psc_cmp_if.sv
// Interface: committed compare values and active configuration between the top and helpers
`timescale 1ns/100ps
`default_nettype none
interface psc_cmp_if;
  logic [15:0] set_a;
  logic [15:0] reset_a;
  logic [15:0] set_b;
  logic [15:0] reset_b;
  logic [7:0] soc;
  logic [7:0] cfg;
  logic [7:0] matrix;
  modport src (output set_a, reset_a, set_b, reset_b, soc, cfg, matrix);
  modport dst (input set_a, reset_a, set_b, reset_b, soc, cfg, matrix);
endinterface
`default_nettype wire

// >>> rtl/psc_match.sv
// Module: compare matches of the committed values against the counter
`timescale 1ns/100ps
`default_nettype none
module psc_match
  import psc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [CMP_W-1:0] count_in,
  psc_cmp_if.dst cmp,
  output logic sa_hit_out,
  output logic ra_hit_out,
  output logic sb_hit_out,
  output logic rb_hit_out
);
  // Twelve-bit compare, flank width bits of RB ignored
  function automatic logic hit(input logic [15:0] v, input logic [CMP_W-1:0] c);
    hit = (v[CMP_W-1:0] == c);
  endfunction
  // Combinational matches; registered downstream in the top
  always_comb begin
    sa_hit_out = hit(cmp.set_a, count_in);
    ra_hit_out = hit(cmp.reset_a, count_in);
    sb_hit_out = hit(cmp.set_b, count_in);
    rb_hit_out = hit(cmp.reset_b, count_in);
  end
  property p_rb_hit;
    @(posedge clk_in) disable iff (rst_in) rb_hit_out == (cmp.reset_b[11:0] == count_in);
  endproperty
  a_rb_hit: assert property (p_rb_hit) else $error("RB match wrong");
endmodule
`default_nettype wire

// >>> rtl/psc_outsel.sv
// Module: pin output selection, polarity and matrix for the four waveform outputs
`timescale 1ns/100ps
`default_nettype none
module psc_outsel
  import psc_pkg::*;
(
  input wire logic wave_a_in,
  input wire logic wave_b_in,
  input wire logic [1:0] ramp_in,
  psc_cmp_if.dst cmp,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_out
);
  logic a_lvl;
  logic b_lvl;
  // Matrix overrides generators and polarity
  always_comb begin
    if (cmp.cfg[CFG_MATRIX]) begin
      a_lvl = cmp.matrix[ramp_in];
      b_lvl = cmp.matrix[{1'b1, ramp_in}];
    end else begin
      a_lvl = cmp.cfg[CFG_POL] ? wave_a_in : ~wave_a_in;
      b_lvl = cmp.cfg[CFG_POL] ? wave_b_in : ~wave_b_in;
    end
    pin_out[0] = a_lvl;
    pin_out[1] = b_lvl;
    pin_out[2] = cmp.soc[SOC_C_SEL] ? b_lvl : a_lvl;
    pin_out[3] = cmp.soc[SOC_D_SEL] ? a_lvl : b_lvl;
    pin_oe_out[0] = cmp.soc[SOC_A_EN];
    pin_oe_out[1] = cmp.soc[SOC_B_EN];
    pin_oe_out[2] = cmp.soc[SOC_C_EN];
    pin_oe_out[3] = cmp.soc[SOC_D_EN];
  end
endmodule
`default_nettype wire

// >>> bench/psc_drv_model.sv
// Far-side model: gate drivers behind the four pins and the ADC trigger input
`timescale 1ns/100ps
`default_nettype none
module psc_drv_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_oe_in,
  input wire logic adc_sync_in,
  output logic [3:0] gate_out,
  output logic [7:0] trig_cnt_out,
  output logic [7:0] wide_cnt_out
);
  logic last_sync;
  // A pin left to the port sits on the driver pull-down, so it reads 0
  assign gate_out = pin_in & pin_oe_in;
  // Trigger starts are counted; a pulse held over two cycles counts as too wide
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_sync <= 1'b0;
      trig_cnt_out <= 8'h00;
      wide_cnt_out <= 8'h00;
    end else begin
      last_sync <= adc_sync_in;
      if (adc_sync_in && !last_sync) trig_cnt_out <= trig_cnt_out + 8'h01;
      if (adc_sync_in && last_sync) wide_cnt_out <= wide_cnt_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> bench/power_stage_pwm_config_irq_test.sv
// Testbench: register port, pins, ADC sync, interrupts and write locks
`timescale 1ns/100ps
`default_nettype none
module power_stage_pwm_config_irq_test;
  import psc_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, down = 1'b0;
  logic wa = 1'b1, wb = 1'b0;
  // Pulsed inputs: fault A, fault B, retrigger, capture, sync error, cycle end
  logic [5:0] pls = 6'h00;
  logic [3:0] addr = 4'h0, enh = 4'h0, pin, oe, gate, flank;
  logic [7:0] wdata = 8'h00, rdata, trig, wide, d;
  logic [11:0] cnt = 12'hFFF;
  logic [1:0] ramp = 2'h0, mode;
  logic sync, irq, fast;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  localparam logic [7:0] POL = 8'h04;
  localparam int P_FA = 0, P_FB = 1, P_RTR = 2, P_CAP = 3, P_SERR = 4, P_CEND = 5;
  psc_ctrl psc_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .count_in(cnt), .count_down_in(down),
    .cycle_end_in(pls[P_CEND]), .enh_cycle_in(enh), .ramp_in(ramp), .wave_a_in(wa),
    .wave_b_in(wb), .fault_a_in(pls[P_FA]), .fault_b_in(pls[P_FB]),
    .retrigger_in(pls[P_RTR]), .capture_in(pls[P_CAP]),
    .sync_error_in(pls[P_SERR]), .wave_pin_out(pin), .wave_pin_oe_out(oe), .adc_sync_out(sync),
    .irq_out(irq), .fast_clock_select_out(fast), .ramp_mode_select_out(mode),
    .flank_width_out(flank));
  psc_drv_model psc_drv_model_inst (.clk_in(clk_in), .rst_in(rst_in), .pin_in(pin),
    .pin_oe_in(oe), .adc_sync_in(sync), .gate_out(gate), .trig_cnt_out(trig),
    .wide_cnt_out(wide));
  // ==========================================
  // Clock, hang guard and shared tasks
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // Whole run is just under two thousand cycles; the ceiling leaves wide margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Strobes drop one edge after raising, so back-to-back calls leave a one-cycle gap
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // High byte first so the low write commits both halves together
  task automatic wr_cmp(input logic [3:0] lo, input logic [15:0] v);
    wr_reg(lo + 4'h1, v[15:8]);
    wr_reg(lo, v[7:0]);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_in);
    pls[b] <= 1'b1;
    @(posedge clk_in);
    pls[b] <= 1'b0;
    tick(4);
  endtask
  task automatic done(input string name);
    $display("test %s finished, errors so far %0d", name, error_cnt);
  endtask
  // Sweep the counter 0..lim once and count ADC trigger starts
  task automatic sweep(input logic [7:0] soc, input logic [7:0] cfg, input logic dn,
                       input int lim, input logic [7:0] exp);
    logic [7:0] t0;
    wr_reg(REG_SYNC_OUT_CFG, soc);
    wr_reg(REG_CTRL_CFG, cfg);
    tick(4);
    t0 = trig;
    down <= dn;
    for (int i = 0; i <= lim; i++) begin
      @(posedge clk_in);
      cnt <= 12'(i);
    end
    @(posedge clk_in);
    cnt <= 12'hFFF;
    tick(5);
    chk(trig - t0, exp, "sync pulses");
    chk(mode, cfg[4:3], "mode field");
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk({pin, oe, 2'b00, sync, irq}, 16'h0000, "outputs after reset");
    rd_reg(REG_SYNC_OUT_CFG, d);
    chk(d, RESET_BYTE, "sync cfg reset");
    rd_reg(REG_CTRL_CFG, d);
    chk(d, RESET_BYTE, "ctrl cfg reset");
    wr_cmp(REG_SET_A_LO, 16'h0ABC);
    rd_reg(REG_SET_A_LO, d);
    chk(d, 8'h00, "compare is write only");
    rd_reg(REG_SET_A_HI, d);
    chk(d, 8'h00, "compare high is write only");
    rd_reg(4'hF, d);
    chk(d, 8'h00, "unmapped read");
    wr_reg(REG_CTRL_CFG, 8'h1E);
    rd_reg(REG_CTRL_CFG, d);
    chk(d, 8'h1E, "ctrl cfg readback");
    chk({fast, mode}, 3'b111, "fast and mode outputs");
    wr_reg(REG_CTRL_CFG, POL);
    done("reset");
  endtask
  task automatic t_pins;
    logic [7:0] soc[4] = '{8'h0F, 8'hCF, 8'h05, 8'h0F};
    logic [1:0] wv[4] = '{2'b01, 2'b01, 2'b01, 2'b10};
    logic [3:0] eg[4] = '{4'b0101, 4'b1001, 4'b0001, 4'b1010};
    logic [3:0] eo[4] = '{4'hF, 4'hF, 4'h3, 4'hF};
    for (int i = 0; i < 4; i++) begin
      wr_reg(REG_SYNC_OUT_CFG, soc[i]);
      @(posedge clk_in);
      {wb, wa} <= wv[i];
      tick(4);
      chk(gate, eg[i], "pin levels");
      chk(oe, eo[i], "pin enables");
    end
    wr_reg(REG_CTRL_CFG, 8'h00);
    tick(4);
    chk(gate, 4'b0101, "active low pins");
    wr_reg(REG_CTRL_CFG, POL);
    done("pins");
  endtask
  task automatic t_sync;
    logic [7:0] t0;
    wr_cmp(REG_SET_A_LO, 16'd10);
    wr_cmp(REG_RESET_A_LO, 16'd20);
    wr_cmp(REG_SET_B_LO, 16'd30);
    wr_cmp(REG_RESET_B_LO, 16'd40);
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 4; c++) sweep(8'(c << 4), 8'(m << 3) | POL, 1'b0, 63, 8'h01);
    for (int c = 0; c < 4; c++)
      for (int dn = 0; dn < 2; dn++)
        sweep(8'(c << 4), 8'h18 | POL, 1'(dn), 63, 8'((c == 0 && dn == 1) || (c == 1 && dn == 0)));
    wr_reg(REG_SYNC_OUT_CFG, 8'h10);
    wr_reg(REG_CTRL_CFG, POL);
    t0 = trig;
    pulse(P_FA);
    chk(trig - t0, 8'h01, "fault A sync");
    wr_reg(REG_SYNC_OUT_CFG, 8'h30);
    pulse(P_FB);
    chk(trig - t0, 8'h02, "fault B sync");
    chk(wide, 8'h00, "sync pulse width");
    done("sync");
  endtask
  task automatic irq_hit(input logic [7:0] en, input logic [3:0] e, input logic [7:0] exp);
    wr_reg(REG_IRQ_ENABLE, en);
    @(posedge clk_in);
    enh <= e;
    cnt <= 12'd40;
    @(posedge clk_in);
    cnt <= 12'hFFF;
    tick(4);
    rd_reg(REG_IRQ_STATUS, d);
    chk(d, exp, "status after match");
    chk(irq, |exp, "irq line");
    wr_reg(REG_IRQ_STATUS, 8'h07);
    tick(3);
    chk(irq, 1'b0, "irq after clear");
  endtask
  // A capture source raises the line, and a write-one clear drops it again
  task automatic capture_event_irq_hit(input int b);
    pulse(b);
    chk(irq, 1'b1, "capture source irq");
    wr_reg(REG_IRQ_STATUS, 8'h04);
    tick(3);
    chk(irq, 1'b0, "capture irq cleared");
  endtask
  task automatic t_irq;
    irq_hit(8'h00, 4'h0, 8'h00);
    irq_hit(8'h01, 4'h0, 8'h01);
    irq_hit(8'h02, 4'hE, 8'h00);
    irq_hit(8'h02, LAST_ENH_CYCLE, 8'h02);
    wr_reg(REG_IRQ_ENABLE, 8'h04);
    capture_event_irq_hit(P_RTR);
    capture_event_irq_hit(P_CAP);
    capture_event_irq_hit(P_SERR);
    done("irq");
  endtask
  task automatic t_lock;
    wr_reg(REG_CTRL_CFG, 8'h20 | POL);
    wr_cmp(REG_RESET_B_LO, 16'hA028);
    tick(4);
    chk(flank, 4'h0, "held by manual lock");
    wr_reg(REG_CTRL_CFG, POL);
    tick(4);
    chk(flank, 4'hA, "released lock");
    wr_reg(REG_CTRL_CFG, 8'h60 | POL);
    wr_cmp(REG_RESET_B_LO, 16'h5028);
    tick(4);
    chk(flank, 4'hA, "held by autolock");
    pulse(P_CEND);
    chk(flank, 4'h5, "autolock commit at cycle end");
    wr_cmp(REG_RESET_B_LO, 16'h6028);
    wr_cmp(REG_SET_A_LO, 16'd10);
    pulse(P_CEND);
    chk(flank, 4'h5, "no commit when RB not last");
    wr_cmp(REG_RESET_B_LO, 16'h7028);
    pulse(P_CEND);
    chk(flank, 4'h7, "commit with RB last");
    wr_reg(REG_CTRL_CFG, POL);
    done("lock");
  endtask
  task automatic t_half_matrix;
    wr_reg(REG_CTRL_CFG, 8'h80 | POL);
    wr_cmp(REG_SET_B_LO, 16'd5);
    wr_cmp(REG_RESET_B_LO, 16'd9);
    sweep(8'h00, 8'h80 | POL, 1'b0, 7, 8'h01);
    sweep(8'h10, 8'h80 | POL, 1'b0, 12, 8'h01);
    wr_reg(REG_MATRIX, 8'h21);
    wr_reg(REG_SYNC_OUT_CFG, 8'h05);
    wr_reg(REG_CTRL_CFG, 8'h11);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_in);
      ramp <= 2'(r);
      tick(4);
      chk(gate[1:0], r ? 2'b10 : 2'b01, "matrix pins");
    end
    done("half duty and matrix");
  endtask
  // ==========================================
  // Closing report and main sequence
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    rst_in <= 1'b0;
    tick(1);
    t_reset();
    t_pins();
    t_sync();
    t_irq();
    t_lock();
    t_half_matrix();
    close_out();
  end
endmodule
`default_nettype wire
